// ===== sim/audio_rx_bit_clock_config_tb.sv
/*
  self-checking bench for rx_bclk_config with a codec model on the pin.
  assumes the package and design are compiled first.
*/
module audio_rx_bit_clock_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PAD_DLY = 2;
  `define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("ERROR %0t %s", $time, m); end end
  logic        aclk = 1'b0, aresetn = 1'b0, tx_bclk = 1'b0, tx_run = 1'b0, codec_run = 1'b0, codec_din = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0]  mclk_tick = 3'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_bclk_i, rx_bclk_o;
  logic        rx_bclk_oe, rx_data_i, rx_bit_q, rx_bit_valid_q, rx_drive_strobe, rx_use_tx_frame_sync;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          failures = 0, samples_checked = 0, tick_n = 0;

  rx_bclk_config DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mclk_tick, .rx_bclk_i, .rx_bclk_o, .rx_bclk_oe, .tx_bclk, .rx_data_i, .rx_bit_q, .rx_bit_valid_q,
    .rx_drive_strobe, .rx_use_tx_frame_sync);
  codec_model #(.HALF(4), .PAD_DLY(PAD_DLY)) codec (.aclk, .run(codec_run), .din(codec_din), .bclk_o(rx_bclk_o),
    .bclk_oe(rx_bclk_oe), .bclk_i(rx_bclk_i), .data(rx_data_i));

  always #10 aclk = ~aclk;
  // master clock options tick every 2, 3 and 4 cycles so each select shows its own period
  always @(posedge aclk) begin
    tick_n <= tick_n + 1;
    mclk_tick <= {tick_n % 4 == 0, tick_n % 3 == 0, tick_n % 2 == 0};
    if (tx_run && tick_n % 3 == 0) tx_bclk <= ~tx_bclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    // let one edge pass so a following call never re-raises bready in this time step
    @(posedge aclk);
    if (k == 64) begin failures++; final_report(); end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ar, v;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (k == 64) begin failures++; final_report(); end
  endtask : rd

  task automatic setup(input logic [31:0] v);
    logic [1:0] r;
    wr(rx_bclk_pkg::CTRL_ADDR, 32'h00000000, r);  // receiver off before config
    wr(rx_bclk_pkg::CONFIG_ADDR, v, r);
    wr(rx_bclk_pkg::CTRL_ADDR, 32'h80000000, r);
  endtask : setup

  // p: cycles between two rises of the generated clock; g: rise to first drive strobe
  task automatic meas(output int p, output int g);
    int k, n;
    logic l;
    n = 0;
    p = 0;
    g = 0;
    l = 1'b1;
    for (k = 0; k < 1100 && n < 2; k++) begin
      @(negedge aclk);
      if (n == 1) p++;
      if (n == 1 && rx_drive_strobe && g == 0) g = p;
      if (rx_bclk_o && !l) n++;
      l = rx_bclk_o;
    end
    if (n < 2) begin failures++; final_report(); end
  endtask : meas

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        b;
    int          n, p, g0, g1;
    logic [7:0]  divs [4] = '{8'hff, 8'h02, 8'h00, 8'h01};
    logic [31:0] swp [3] = '{32'h00000000, 32'h20000000, 32'h40000000};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(rx_bclk_oe, 1'b0, "pin driven after reset");
    rd(rx_bclk_pkg::CONFIG_ADDR, d, r);
    `CHK(d, rx_bclk_pkg::CONFIG_RESET, "config reset value");
    wr(rx_bclk_pkg::CONFIG_ADDR, 32'hffffffff, r);
    rd(rx_bclk_pkg::CONFIG_ADDR, d, r);
    `CHK(d, 32'hff0000ff, "config readback");
    `CHK(rx_bclk_oe, 1'b1, "master not driving pin");
    wr(12'h0fc, 32'h00000000, r);
    `CHK(r, rx_bclk_pkg::RESP_SLVERR, "unmapped write answer");
    rd(12'h0fc, d, r);
    `CHK({d, r}, {32'h00000000, rx_bclk_pkg::RESP_SLVERR}, "unmapped read answer");
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      setup({4'h0, m[1:0], 2'h1, 16'h0000, divs[m]});
      meas(p, g0);
      `CHK(p, 2 * (divs[m] + 1) * (m == 0 ? 1 : m + 1), "bit clock period");
    end
    $display("test divider done");
    setup(32'h01000004);
    meas(p, g0);
    setup(32'h11000004);
    meas(p, g1);
    `CHK(g1 - g0, PAD_DLY, "pad feedback delay");
    $display("test feedback done");
    codec_run <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      b = i[0];
      codec_din <= b;
      setup({6'h00, b, 1'b0, 24'h000000});
      n = 0;
      repeat (80) begin
        @(negedge aclk);
        if (rx_bit_valid_q) n++;
        if (rx_bit_valid_q) `CHK({rx_bclk_i, rx_bit_q}, {b, b}, "sample edge");
        if (rx_drive_strobe) `CHK(rx_bclk_i, ~b, "drive edge");
      end
      `CHK(n > 0, 1'b1, "no slave samples");
    end
    codec_run <= 1'b0;
    $display("test slave edges done");
    tx_run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      setup(swp[i]);
      n = 0;
      repeat (60) begin
        @(negedge aclk);
        n += rx_bit_valid_q;
      end
      `CHK({n > 0, rx_use_tx_frame_sync}, {i > 0, i == 2}, "clock swap");
    end
    $display("test swap done");
    final_report();
  end
endmodule : audio_rx_bit_clock_config_tb

// ===== sim/codec_model.sv
/*
  external codec on the receive bit-clock pin.
  assumes the pad input follows the driven pin after PAD_DLY cycles.
*/
// ============================================================
// codec
module codec_model #(
  parameter int HALF    = 4,
  parameter int PAD_DLY = 2
) (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic din,
  input  wire logic bclk_o,
  input  wire logic bclk_oe,
  output logic      bclk_i,
  output logic      data
);
  logic [7:0] dly_q = 8'h00;
  logic       clk_q = 1'b0;
  logic       d_q   = 1'b0;
  int         c     = 0;
  always @(posedge aclk) begin
    dly_q <= {dly_q[6:0], bclk_o};
    c <= (run && c < HALF - 1) ? c + 1 : 0;
    if (!run) clk_q <= 1'b0;  // stands still outside frames
    else if (c == HALF - 1) clk_q <= ~clk_q;
    if (run) d_q <= din;
  end
  assign bclk_i = bclk_oe ? dly_q[PAD_DLY-1] : clk_q;
  // released data line shows the inverse so stale bits cannot pass
  assign data = run ? d_q : ~d_q;
endmodule : codec_model

// ===== sim/rx_bclk_props.sv
/*
  port checker for rx_bclk_config, bound to every instance.
  assumes one clock domain and a synchronous active-low reset.
*/
// ============================================================
// checker
module rx_bclk_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_bclk_o,
  input wire logic        rx_bclk_oe,
  input wire logic        rx_bit_valid_q,
  input wire logic        rx_drive_strobe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic cfg_q;  // read in flight targets the config word
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) cfg_q <= s_axi_araddr == rx_bclk_pkg::CONFIG_ADDR;
  end
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  rsvd_zero_a: assert property (s_axi_rvalid && cfg_q |-> s_axi_rdata[23:8] == 16'h0000)
    else $error("reserved bits read nonzero");
  sample_once_a: assert property (rx_bit_valid_q |=> !rx_bit_valid_q) else $error("sample strobe too long");
  drive_once_a: assert property (rx_drive_strobe |=> !rx_drive_strobe) else $error("drive strobe too long");
  slave_quiet_a: assert property (!rx_bclk_oe [*3] |-> !rx_bclk_o) else $error("slave drives bit clock");
  cover property (s_axi_bvalid && s_axi_bresp == rx_bclk_pkg::RESP_SLVERR);
  cover property (rx_bit_valid_q && rx_bclk_oe);
  cover property ($rose(rx_bclk_oe));
endmodule : rx_bclk_props

bind rx_bclk_config rx_bclk_props chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_bclk_o, .rx_bclk_oe, .rx_bit_valid_q, .rx_drive_strobe);

// ===== verilog/bclk_divider.sv
/*
  bit-clock generator: toggles its output every (div + 1) source ticks, so
  the generated clock period is 2 * (div + 1) ticks of the selected source.
  assumes src_tick is a one-cycle enable pulse on aclk (or tied high for aclk).
*/
module bclk_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             run,
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] div,
  output logic                  bclk_q
);

  // ==========================================================================
  // tick counter
  logic [DIV_W-1:0] count_q;
  logic [DIV_W-1:0] count_d;
  logic             wrap;

  assign wrap    = src_tick && (count_q >= div);
  assign count_d = wrap ? '0 : count_q + DIV_W'(1);

  // stopped generator parks low so a restart begins with a full low phase
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= '0;
      bclk_q  <= 1'b0;
    end else if (src_tick) begin
      count_q <= count_d;
      if (wrap) begin
        bclk_q <= ~bclk_q;
      end
    end
  end

endmodule : bclk_divider

// ===== verilog/bclk_edges.sv
/*
  edge finder for the bit clock in use: one-cycle strobes for the sample edge
  and the drive edge, chosen by the polarity bit.
  assumes bclk is already synchronous to aclk and slower than aclk / 2.
*/
module bclk_edges (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic bclk,
  output logic      level_q,
  output logic      sample_q,
  output logic      drive_q
);

  // ==========================================================================
  // edges
  logic rise;
  logic fall;

  assign rise = bclk && !level_q;
  assign fall = !bclk && level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q  <= 1'b0;
      sample_q <= 1'b0;
      drive_q  <= 1'b0;
    end else begin
      level_q  <= bclk;
      sample_q <= enable && (polarity ? rise : fall);
      drive_q  <= enable && (polarity ? fall : rise);
    end
  end

endmodule : bclk_edges

// ===== verilog/rx_bclk_config.sv
/*
  receive bit-clock configuration: register file on axi4-lite, bit-clock
  source selection, generator and the edge strobes of the receiver.
  assumes all pin inputs and master clock ticks are synchronous to aclk and
  that software does not rewrite the configuration register while enabled.
*/
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
// Function
// - the swap bit picks the normal bit clock at 0 and the alternate one at 1; the code applies it in sync modes 0 and 1 only.
// - with feedback set and an internal bit clock the receiver runs from the pad input, not the internal clock.
// - the two-bit master clock select picks bus clock or master clock option one to three for the generator.
// - polarity 0 drives on the rising edge and samples on the falling one; polarity 1 the reverse.
// - direction 0 takes the bit clock from outside as slave; direction 1 generates and drives it as master.
// - the generated bit clock is the selected source divided by twice (divider value plus one).
// - bits 23 to 8 of the configuration register are read-only zero.
// - in asynchronous mode with swap set the receiver takes the transmitter bit clock but keeps its own frame sync.
module rx_bclk_config (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // master clock option ticks 1..3
  input  wire logic [2:0]  mclk_tick,
  // receive bit-clock pin
  input  wire logic        rx_bclk_i,
  output logic             rx_bclk_o,
  output logic             rx_bclk_oe,
  // transmitter bit clock, for sharing
  input  wire logic        tx_bclk,
  // serial data and receiver strobes
  input  wire logic        rx_data_i,
  output logic             rx_bit_q,
  output logic             rx_bit_valid_q,
  output logic             rx_drive_strobe,
  output logic             rx_use_tx_frame_sync
);

  // ==========================================================================
  // registers
  logic [31:0] config_q;
  logic        enable_q;

  logic [1:0]  sync_mode;
  logic        swap;
  logic        feedback;
  logic [1:0]  master_clock_source_select;
  logic        polarity;
  logic        direction;
  logic [7:0]  div;

  assign sync_mode = config_q[rx_bclk_pkg::SYNC_LSB +: 2];
  assign swap      = config_q[rx_bclk_pkg::SWAP_BIT];
  assign feedback  = config_q[rx_bclk_pkg::FEEDBACK_BIT];
  assign master_clock_source_select      = config_q[rx_bclk_pkg::MASTER_CLOCK_SOURCE_SELECT_LSB +: 2];
  assign polarity  = config_q[rx_bclk_pkg::POLARITY_BIT];
  assign direction = config_q[rx_bclk_pkg::DIRECTION_BIT];
  assign div       = config_q[rx_bclk_pkg::DIV_LSB +: rx_bclk_pkg::DIV_W];

  // ==========================================================================
  // axi write channel: address and data taken in either order
  logic        aw_held_q;
  logic [11:0] awaddr_q;
  logic        w_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  logic        do_write;
  logic        wr_config;
  logic        wr_ctrl;
  logic [31:0] strb_mask;
  logic [31:0] config_wr;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  assign do_write  = aw_held_q && w_held_q && !bvalid_q;
  assign wr_config = do_write && (awaddr_q == rx_bclk_pkg::CONFIG_ADDR);
  assign wr_ctrl   = do_write && (awaddr_q == rx_bclk_pkg::CTRL_ADDR);
  assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // reserved middle bits never store, so they always read back as zero
  assign config_wr = (config_q & ~strb_mask) | (wdata_q & strb_mask & rx_bclk_pkg::CONFIG_WMASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= {s_axi_awaddr[11:2], 2'h0};
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= rx_bclk_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_config || wr_ctrl) ? rx_bclk_pkg::RESP_OKAY : rx_bclk_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // no lock on the configuration while enabled: changing it mid-stream is
  // the caller's hazard, and a lock would hide such software faults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= rx_bclk_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      config_q <= config_wr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= rx_bclk_pkg::ENABLE_RESET;
    end else if (wr_ctrl && wstrb_q[3]) begin
      enable_q <= wdata_q[rx_bclk_pkg::ENABLE_BIT];
    end
  end

  // ==========================================================================
  // bit-clock source selection
  logic src_tick;
  logic gen_bclk;
  logic own_bclk;
  logic use_tx_bclk;
  logic bclk_in_use;

  // bus clock ticks every cycle; options one to three arrive as enables
  assign src_tick = (master_clock_source_select == rx_bclk_pkg::MASTER_CLOCK_SOURCE_SELECT_BUS) ? 1'b1 : mclk_tick[master_clock_source_select - 2'h1];

  bclk_divider #(
    .DIV_W (rx_bclk_pkg::DIV_W)
  ) u_divider (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (direction),
    .src_tick (src_tick),
    .div      (div),
    .bclk_q   (gen_bclk)
  );

  // master drives the pin; slave listens only
  assign rx_bclk_o  = gen_bclk;
  assign rx_bclk_oe = direction;

  // feedback clocks from the pad, trading setup margin for output valid time
  assign own_bclk = (direction && !feedback) ? gen_bclk : rx_bclk_i;

  // swap flips which end's clock the receiver follows in sync modes 0 and 1; the other two modes ignore it and keep the own clock
  assign use_tx_bclk = (sync_mode == rx_bclk_pkg::SYNC_ASYNC)   ? swap :
                       (sync_mode == rx_bclk_pkg::SYNC_WITH_TX) ? !swap :
                       1'b0;
  assign bclk_in_use = use_tx_bclk ? tx_bclk : own_bclk;

  // own frame sync in asynchronous mode, even when the clock is borrowed
  assign rx_use_tx_frame_sync = (sync_mode != rx_bclk_pkg::SYNC_ASYNC);

  // ==========================================================================
  // edge strobes and data capture
  logic bclk_level;
  logic sample_strobe;

  bclk_edges u_edges (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (enable_q),
    .polarity (polarity),
    .bclk     (bclk_in_use),
    .level_q  (bclk_level),
    .sample_q (sample_strobe),
    .drive_q  (rx_drive_strobe)
  );

  logic data_d1_q;

  // data is delayed one cycle to line up with the registered strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_d1_q      <= 1'b0;
      rx_bit_q       <= 1'b0;
      rx_bit_valid_q <= 1'b0;
    end else begin
      data_d1_q      <= rx_data_i;
      rx_bit_valid_q <= sample_strobe;
      if (sample_strobe) begin
        rx_bit_q <= data_d1_q;
      end
    end
  end

  // ==========================================================================
  // axi read channel
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [11:0] araddr_w;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign araddr_w    = {s_axi_araddr[11:2], 2'h0};
  assign status_word = {enable_q, 27'h0, rx_use_tx_frame_sync, use_tx_bclk, direction, bclk_level};
  assign rd_hit      = (araddr_w == rx_bclk_pkg::CONFIG_ADDR) || (araddr_w == rx_bclk_pkg::CTRL_ADDR);
  assign rd_mux      = (araddr_w == rx_bclk_pkg::CONFIG_ADDR) ? config_q :
                       (araddr_w == rx_bclk_pkg::CTRL_ADDR)   ? status_word : 32'h00000000;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= rx_bclk_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? rx_bclk_pkg::RESP_OKAY : rx_bclk_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : rx_bclk_config

// ===== verilog/rx_bclk_pkg.sv
/*
  constants for the receive bit-clock configuration block: register offsets,
  field positions, write masks, reset values and bus answers.
  assumes a 32-bit axi4-lite slave with 12 address bits decoded.
*/
package rx_bclk_pkg;

  // ==========================================================================
  // bus
  localparam int          ADDR_W        = 12;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [11:0] CTRL_ADDR     = 12'h080;
  localparam logic [11:0] CONFIG_ADDR   = 12'h088;

  // ==========================================================================
  // receive_bit_clock_config fields
  localparam int          SYNC_LSB      = 30;
  localparam int          SWAP_BIT      = 29;
  localparam int          FEEDBACK_BIT  = 28;
  localparam int          MASTER_CLOCK_SOURCE_SELECT_LSB      = 26;
  localparam int          POLARITY_BIT  = 25;
  localparam int          DIRECTION_BIT = 24;
  localparam int          DIV_LSB       = 0;
  localparam int          DIV_W         = 8;
  localparam logic [31:0] CONFIG_WMASK  = 32'hff0000ff;
  localparam logic [31:0] CONFIG_RESET  = 32'h00000000;

  // sync field codes
  localparam logic [1:0]  SYNC_ASYNC    = 2'h0;
  localparam logic [1:0]  SYNC_WITH_TX  = 2'h1;

  // master clock select codes
  localparam logic [1:0]  MASTER_CLOCK_SOURCE_SELECT_BUS      = 2'h0;

  // ==========================================================================
  // control / status register fields
  localparam int          ENABLE_BIT    = 31;
  localparam int          ST_LEVEL_BIT  = 0;
  localparam int          ST_MASTER_BIT = 1;
  localparam int          ST_TXCLK_BIT  = 2;
  localparam int          ST_TXSYNC_BIT = 3;
  localparam logic        ENABLE_RESET  = 1'b0;

endpackage : rx_bclk_pkg
